// ### src/two_wire_byte_eeprom_slave.sv
// top of the two-wire byte memory slave: protocol engine on the link clock
`timescale 1ns/1ps
`include "eeprom_params.svh"
module two_wire_byte_eeprom_slave #(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic prog_busy,
  output eeprom_pkg::addr_t last_addr
);
  import eeprom_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // shift one sampled bit in at the low end, msb arrives first
  function automatic byte_t shift_in_bit(input byte_t cur, input logic bit_in);
    shift_in_bit = {cur[`DATA_W-2:0], bit_in};
  endfunction : shift_in_bit

  // true when the counter shows the given number of bits taken
  function automatic logic cnt_is(input bit_cnt_t cnt, input bit_cnt_t val);
    cnt_is = (cnt == val);
  endfunction : cnt_is

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------

  // registers of the link domain and their next values
  logic [1:0] pin_s;
  logic scl_q_reg;
  logic sda_q_reg;
  link_state_e state_reg;
  link_state_e state_next;
  bit_cnt_t bit_cnt_reg;
  bit_cnt_t bit_cnt_next;
  byte_t shift_reg;
  byte_t shift_next;
  addr_t addr_reg;
  addr_t addr_next;
  byte_t mem_reg [`ARRAY_DEPTH];
  logic req_tgl_reg;
  logic req_tgl_next;
  logic ack_s;
  logic sda_out_reg;
  logic sda_out_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic busy_reg;
  logic busy_next;

  // decode nets, all combinational
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire in_idle;
  wire in_ctrl;
  wire in_wdata;
  wire in_prog;
  wire in_rdata;
  wire in_input;
  wire guard_bit;
  wire start_take;
  wire stop_take;
  wire byte_done;
  wire ctrl_done;
  wire wdata_done;
  wire read_last_fall;
  wire prog_done;
  wire [`DATA_W-1:0] shifted;
  wire [1:0] ctrl_cmd_bits;
  cmd_e ctrl_cmd;
  wire [`ADDR_W-1:0] ctrl_addr;
  wire [`DATA_W-1:0] read_byte;
  wire ack_toggle_w;

  // ----------------------------------------------------------------
  // pin synchronisers and clock crossing
  // ----------------------------------------------------------------

  // serial clock and data are sampled by the link clock, two stages first
  // a pin may move at any instant against link_clk, so nothing reads it before both stages
  sync_2ff #(.WIDTH(2)) u_pin_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .async_in({serial_clock_pin, serial_data_pin_in}),
    .sync_out(pin_s)
  );

  // programming interval is timed in the core domain
  // request and answer travel as toggles, so one changing bit crosses each way
  prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_prog_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .req_toggle(req_tgl_reg),
    .ack_toggle(ack_toggle_w)
  );

  // answer toggle comes back from the core domain
  sync_2ff #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .rst_n(rst_n),
    .async_in(ack_toggle_w),
    .sync_out(ack_s)
  );

  // ----------------------------------------------------------------
  // line event decode
  // ----------------------------------------------------------------

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // edges of the synchronised serial clock
  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;

  // data moving while the clock stays high marks start or stop
  // both samples must show the clock high, so a clock edge cannot fake a start
  assign start_cond = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_cond = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // state decode
  // comparing the whole code keeps an illegal value from looking like a state
  assign in_idle = (state_reg == ST_IDLE);
  assign in_ctrl = (state_reg == ST_CTRL);
  assign in_wdata = (state_reg == ST_WDATA);
  assign in_prog = (state_reg == ST_PROG);
  assign in_rdata = (state_reg == ST_RDATA);
  assign in_input = in_ctrl | in_wdata;

  // period of the second don't-care bit: seven control bits already in
  // the master may release the line here; a wandering level must not read as start or stop
  assign guard_bit = in_ctrl & cnt_is(bit_cnt_reg, `LAST_BIT_IDX);

  // starts count from standby or input phases; read-out and programming ignore both
  assign start_take = start_cond & (in_idle | (in_input & ~guard_bit));
  assign stop_take = stop_cond & in_input & ~guard_bit;

  // byte completion on the eighth rising edge
  assign byte_done = scl_rise & cnt_is(bit_cnt_reg, `LAST_BIT_IDX);
  assign ctrl_done = in_ctrl & byte_done;
  assign wdata_done = in_wdata & byte_done;
  assign read_last_fall = in_rdata & scl_fall & cnt_is(bit_cnt_reg, `BITS_PER_BYTE);
  assign prog_done = in_prog & (ack_s == req_tgl_reg);

  // control byte fields as they stand once the last bit is shifted in
  assign shifted = shift_in_bit(shift_reg, sda_s);
  assign ctrl_cmd_bits = shifted[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
  assign ctrl_cmd = cmd_e'(ctrl_cmd_bits);
  assign ctrl_addr = shifted[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
  assign read_byte = mem_reg[ctrl_addr];

  // ----------------------------------------------------------------
  // protocol state machine
  // ----------------------------------------------------------------

  // next state; stop wins over start since they cannot both occur in one sample
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_take) begin
          state_next = ST_CTRL;
        end
      end
      ST_CTRL: begin
        if (stop_take) begin
          state_next = ST_IDLE;
        end else if (start_take) begin
          state_next = ST_CTRL;
        end else if (ctrl_done) begin
          case (ctrl_cmd)
            CMD_WRITE: state_next = ST_WDATA;
            CMD_READ: state_next = ST_RDATA;
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_WDATA: begin
        if (stop_take) begin
          state_next = ST_IDLE;
        end else if (start_take) begin
          state_next = ST_CTRL;
        end else if (wdata_done) begin
          state_next = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          state_next = ST_IDLE;
        end
      end
      // read-out ends at the fall after the eighth read clock, so the last bit keeps its high phase
      ST_RDATA: begin
        if (read_last_fall) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // counters, shift register and line drive
  // ----------------------------------------------------------------

  // bit counter: cleared by start, stop, byte end, read end and programming end
  // a stop brings its own clock rise: a stop after seven data bits clocks the eighth and programs
  assign bit_cnt_next = (start_take | stop_take | byte_done & in_input | read_last_fall | prog_done) ? '0 :
                        ((in_input | in_rdata) & scl_rise) ? bit_cnt_reg + 1'b1 : bit_cnt_reg;

  // shift register: sample in, load for read, move left after each read bit
  assign shift_next = (start_take | stop_take) ? '0 :
                      (ctrl_done & (ctrl_cmd == CMD_READ)) ? read_byte :
                      ctrl_done ? '0 :
                      (in_input & scl_rise) ? shifted :
                      (in_rdata & scl_rise) ? {shift_reg[`DATA_W-2:0], 1'b0} : shift_reg;

  // address latched with the control byte
  assign addr_next = ctrl_done ? ctrl_addr : addr_reg;

  // each write hands one toggle to the programming timer
  assign req_tgl_next = req_tgl_reg ^ wdata_done;

  // read bits change only after a falling clock, msb first
  assign sda_out_next = (in_rdata & scl_fall & ~cnt_is(bit_cnt_reg, `BITS_PER_BYTE)) ? shift_reg[`DATA_W-1] :
                        sda_out_reg;

  // drive starts at the fall ending the guard bit, master has released by then
  assign sda_oe_next = (in_rdata & scl_fall) ? ~cnt_is(bit_cnt_reg, `BITS_PER_BYTE) :
                       (in_rdata & sda_oe_reg);

  // busy flag follows the programming state
  // set together with the state register, so it never lags the interval's start
  assign busy_next = (state_next == ST_PROG);

  // ----------------------------------------------------------------
  // link-domain registers
  // ----------------------------------------------------------------

  // state, counter and line registers
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b0;
      sda_q_reg <= 1'b0;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      addr_reg <= '0;
      req_tgl_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      req_tgl_reg <= req_tgl_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg <= sda_oe_next;
      busy_reg <= busy_next;
    end
  end

  // sixteen-byte array, written once the eighth data bit is in
  // no read register here: the read byte goes straight into the shift register
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `ARRAY_DEPTH; i++) begin
        mem_reg[i] <= `ARRAY_RESET_VAL;
      end
    end else if (wdata_done) begin
      mem_reg[addr_reg] <= shifted;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // every output is a plain copy of a link-domain register
  assign serial_data_pin_out = sda_out_reg;
  assign serial_data_pin_oe = sda_oe_reg;
  assign prog_busy = busy_reg;
  assign last_addr = addr_reg;
endmodule : two_wire_byte_eeprom_slave

// ### src/eeprom_params.svh
// constants for the two-wire byte memory slave
// Summary of operation
// - data changes only while the serial clock is low; high-clock changes mean start or stop
// - start is data falling with clock high; ignore everything until a start
// - stop is data rising with clock high; resets command input to standby
// - start during control or write data input aborts it, ready for a new command
// - start and stop ignored while driving read data or programming
// - control byte: two-bit command, four address bits, two don't-care bits; 0,1 writes
// - after a write control byte, eight more clocks shift in one data byte
// - after the eighth data clock program the addressed byte, ignoring all input meanwhile
// - start or stop before the last data bit cancels the write and clears counters
// - when programming ends, clear counters and return to standby by itself
// - a read is a start then a control byte with command 1,0
// - after a read control byte load the addressed byte and shift it out
// - after the read byte is shifted out, clear counters and return to standby
// - start or stop during read command or address bits aborts the read
// - ignore start and stop during the second don't-care clock period
// - device drives the data line both high and low when sending
// - array holds sixteen bytes; four address bits pick one byte
// - during programming, up to 5 ms, the line is undriven and starts ignored
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
`define ARRAY_DEPTH 16
`define ADDR_W 4
`define DATA_W 8
`define BIT_CNT_W 4
`define CTRL_CMD_MSB 7
`define CTRL_CMD_LSB 6
`define CTRL_ADDR_MSB 5
`define CTRL_ADDR_LSB 2
`define CMD_WRITE_CODE 2'h1
`define CMD_READ_CODE 2'h2
`define ARRAY_RESET_VAL 8'hFF
`define LAST_BIT_IDX 4'h7
`define BITS_PER_BYTE 4'h8
`define PROG_TIME_MS 5
`define CORE_CLK_KHZ 20000
`define PROG_CYCLES (`PROG_TIME_MS * `CORE_CLK_KHZ)
`define PROG_CNT_W 17
`endif

// ### src/eeprom_pkg.sv
// types shared by the two-wire byte memory slave
`include "eeprom_params.svh"
package eeprom_pkg;
  // link-side protocol states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CTRL = 5'h02,
    ST_WDATA = 5'h04,
    ST_PROG = 5'h08,
    ST_RDATA = 5'h10
  } link_state_e;
  // two-bit command field of the control byte
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_WRITE = `CMD_WRITE_CODE,
    CMD_READ = `CMD_READ_CODE,
    CMD_BOTH = 2'h3
  } cmd_e;
  typedef logic [`DATA_W-1:0] byte_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`BIT_CNT_W-1:0] bit_cnt_t;
endpackage : eeprom_pkg

// ### src/sync_2ff.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : sync_2ff

// ### src/prog_timer.sv
// core-clock timer for the self-timed programming interval
`timescale 1ns/1ps
`include "eeprom_params.svh"
module prog_timer
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_toggle,
  output logic ack_toggle
);
  localparam logic [`PROG_CNT_W-1:0] LAST_CNT = `PROG_CNT_W'(PROG_CYCLES - 1);

  logic req_s;
  logic req_seen_reg;
  logic running_reg;
  logic [`PROG_CNT_W-1:0] count_reg;
  logic ack_reg;
  wire start_evt;
  wire done;

  // request toggle comes from the link clock domain
  sync_2ff #(.WIDTH(1)) u_req_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .async_in(req_toggle),
    .sync_out(req_s)
  );

  // a change of the toggle starts one interval; the last count toggles the answer
  assign start_evt = req_s ^ req_seen_reg;
  assign done = running_reg && (count_reg == LAST_CNT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_reg <= 1'b0;
      running_reg <= 1'b0;
      count_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_s;
      running_reg <= start_evt | (running_reg & ~done);
      count_reg <= (start_evt | done) ? '0 : (running_reg ? count_reg + 1'b1 : count_reg);
      ack_reg <= ack_reg ^ done;
    end
  end

  assign ack_toggle = ack_reg;
endmodule : prog_timer

// ### verif/eeprom_slave_props.sv
// assertion checker for the two-wire byte memory slave
`timescale 1ns/1ps
module eeprom_slave_props #(
  parameter int PROG_CYCLES = 100000
) (
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin_in,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic prog_busy,
  input wire eeprom_pkg::addr_t last_addr
);
  import eeprom_pkg::*;
  // --------
  // helpers
  // --------
  logic scl_q_reg;
  logic scl_rise;
  bit_cnt_t rise_cnt_reg;
  int busy_cnt_reg;
  assign scl_rise = serial_clock_pin & ~scl_q_reg;
  // count clock rises while read data is driven
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b0;
      rise_cnt_reg <= 4'h0;
    end else begin
      scl_q_reg <= serial_clock_pin;
      rise_cnt_reg <= serial_data_pin_oe ? rise_cnt_reg + {3'h0, scl_rise} : 4'h0;
    end
  end
  // length of the programming interval in core cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_reg <= 0;
    else
      busy_cnt_reg <= prog_busy ? busy_cnt_reg + 1 : 0;
  end
  property p_bit_hold;
    @(posedge link_clk) disable iff (!rst_n)
      serial_data_pin_oe && serial_clock_pin && $past(serial_clock_pin) |-> $stable(serial_data_pin_out);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("read bit moved");
  property p_idle_prog;
    @(posedge core_clk) disable iff (!rst_n) prog_busy |-> !serial_data_pin_oe;
  endproperty
  a_idle_prog: assert property (p_idle_prog) else $error("driven while busy");
  property p_drive_low;
    @(posedge link_clk) disable iff (!rst_n) $rose(serial_data_pin_oe) |-> !serial_clock_pin [*3];
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive began off low clock");
  property p_eight_bits;
    @(posedge link_clk) disable iff (!rst_n) $fell(serial_data_pin_oe) |-> rise_cnt_reg == 4'h8;
  endproperty
  a_eight_bits: assert property (p_eight_bits) else $error("read length wrong");
  property p_no_extra;
    @(posedge link_clk) disable iff (!rst_n) serial_data_pin_oe |-> rise_cnt_reg <= 4'h8;
  endproperty
  a_no_extra: assert property (p_no_extra) else $error("read too long");
  property p_prog_min;
    @(posedge core_clk) disable iff (!rst_n) $fell(prog_busy) |-> busy_cnt_reg >= PROG_CYCLES;
  endproperty
  a_prog_min: assert property (p_prog_min) else $error("busy too short");
  property p_prog_max;
    @(posedge core_clk) disable iff (!rst_n) prog_busy |-> busy_cnt_reg <= PROG_CYCLES + 16;
  endproperty
  a_prog_max: assert property (p_prog_max) else $error("busy too long");
  property p_addr_prog;
    @(posedge link_clk) disable iff (!rst_n) prog_busy && $past(prog_busy) |-> $stable(last_addr);
  endproperty
  a_addr_prog: assert property (p_addr_prog) else $error("address moved while busy");
  property p_addr_read;
    @(posedge link_clk) disable iff (!rst_n) serial_data_pin_oe |=> $stable(last_addr);
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("address moved in read");
endmodule : eeprom_slave_props
bind two_wire_byte_eeprom_slave eeprom_slave_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .core_clk(core_clk), .link_clk(link_clk), .rst_n(rst_n), .serial_clock_pin(serial_clock_pin),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .prog_busy(prog_busy), .last_addr(last_addr));

// ### verif/two_wire_master_model.sv
// behavioural bus master that clocks the two-wire link
`timescale 1ns/1ps
module two_wire_master_model #(
  parameter int HALF_NS = 405
) (
  output logic scl,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sda_wire
);
  import eeprom_pkg::*;
  // --------
  // idle: both lines driven high, clock still
  // --------
  initial begin
    scl = 1'b1;
    sda_out = 1'b1;
    sda_oe = 1'b1;
  end
  // data falls while the clock is high
  task automatic start_cond();
    sda_out = 1'b1;
    sda_oe = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_out = 1'b0;
    #HALF_NS scl = 1'b0;
  endtask : start_cond
  // reclaim the line, then data rises while the clock is high
  task automatic stop_cond();
    #HALF_NS sda_out = 1'b0;
    sda_oe = 1'b1;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda_out = 1'b1;
  endtask : stop_cond
  // one bit, data set while clock low; rel lets go in the high phase
  task automatic put_bit(input logic b, input logic rel);
    sda_out = b;
    #HALF_NS scl = 1'b1;
    #(HALF_NS / 2) sda_oe = ~rel;
    #(HALF_NS - HALF_NS / 2) scl = 1'b0;
  endtask : put_bit
  task automatic send_byte(input byte_t b, input logic rel);
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], rel && (i == 0));
  endtask : send_byte
  // eight read clocks, bit taken just before each fall
  task automatic get_byte(output byte_t v);
    for (int i = 0; i < 8; i++) begin
      #HALF_NS scl = 1'b1;
      #HALF_NS v = {v[6:0], sda_wire};
      scl = 1'b0;
    end
  endtask : get_byte
  // bit of zero whose data rises in the high phase: a stop unless the slave ignores it
  task automatic put_rising_bit();
    sda_out = 1'b0;
    #HALF_NS scl = 1'b1;
    #(HALF_NS / 2) sda_out = 1'b1;
    #(HALF_NS - HALF_NS / 2) scl = 1'b0;
  endtask : put_rising_bit
endmodule : two_wire_master_model

// ### verif/testbench.sv
// self-checking bench for the two-wire byte memory slave
`timescale 1ns/1ps
module testbench;
  import eeprom_pkg::*;
  localparam int PROG = 300;
  localparam int LIMIT = 20000;
  typedef struct packed {addr_t addr; byte_t data;} row_s;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic float_bit = 1'b0;
  logic m_scl, m_out, m_oe, sda_wire, dut_out, dut_oe, prog_busy;
  addr_t last_addr;
  byte_t rd;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  row_s rows [4] = '{'{4'h0, 8'hA5}, '{4'hF, 8'h5A}, '{4'h1, 8'h00}, '{4'h8, 8'h81}};
  // --------
  // clocks, wire and instances
  // --------
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // no pull-up: a released line wanders
  always @(posedge link_clk) float_bit <= ~float_bit;
  assign sda_wire = dut_oe ? dut_out : (m_oe ? m_out : float_bit);
  two_wire_byte_eeprom_slave #(.PROG_CYCLES(PROG)) dut (.core_clk(core_clk), .link_clk(link_clk),
    .rst_n(rst_n), .serial_clock_pin(m_scl), .serial_data_pin_in(sda_wire), .serial_data_pin_out(dut_out),
    .serial_data_pin_oe(dut_oe), .prog_busy(prog_busy), .last_addr(last_addr));
  two_wire_master_model master (.scl(m_scl), .sda_out(m_out), .sda_oe(m_oe), .sda_wire(sda_wire));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    @(posedge core_clk);
    #3 rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    check({1'b0, dut_oe, dut_out, prog_busy, last_addr}, 8'h00);
    #3 rst_n = 1'b1;
  endtask : do_reset
  task automatic begin_frame();
    @(posedge core_clk);
    #3 master.start_cond();
  endtask : begin_frame
  task automatic write_byte(input addr_t a, input byte_t d);
    begin_frame();
    master.send_byte({CMD_WRITE, a, 2'b00}, 1'b0);
    master.send_byte(d, 1'b0);
    master.stop_cond();
  endtask : write_byte
  task automatic read_byte(input addr_t a, output byte_t d);
    begin_frame();
    master.send_byte({CMD_READ, a, 2'b00}, 1'b1);
    master.get_byte(d);
    master.stop_cond();
  endtask : read_byte
  task automatic wait_idle();
    for (int i = 0; i < 4 * PROG && prog_busy !== 1'b0; i++)
      @(posedge core_clk);
    check({7'h00, prog_busy}, 8'h00);
  endtask : wait_idle
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end
  // --------
  // main sequence: table rows, then awkward cases
  // --------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      write_byte(rows[i].addr, rows[i].data);
      check({7'h00, prog_busy}, 8'h01);
      check({4'h0, last_addr}, {4'h0, rows[i].addr});
      wait_idle();
    end
    foreach (rows[i]) begin
      read_byte(rows[i].addr, rd);
      check(rd, rows[i].data);
      check({7'h00, dut_oe}, 8'h00);
    end
    // codes 00 and 11 neither write nor read
    for (int c = 0; c < 4; c += 3) begin
      begin_frame();
      master.send_byte({c[1:0], 4'h3, 2'b00}, 1'b0);
      master.send_byte(8'h12, 1'b0);
      master.stop_cond();
      check({6'h00, prog_busy, dut_oe}, 8'h00);
    end
    // start after four data bits cancels the write
    begin_frame();
    master.send_byte({CMD_WRITE, 4'h4, 2'b00}, 1'b0);
    for (int i = 0; i < 4; i++)
      master.put_bit(1'b0, 1'b0);
    read_byte(4'h4, rd);
    check(rd, 8'hFF);
    // stop before the last data bit cancels the write; six bits, the stop's own rise is the seventh
    begin_frame();
    master.send_byte({CMD_WRITE, 4'h5, 2'b00}, 1'b0);
    for (int i = 0; i < 6; i++)
      master.put_bit(1'b0, 1'b0);
    master.stop_cond();
    check({7'h00, prog_busy}, 8'h00);
    read_byte(4'h5, rd);
    check(rd, 8'hFF);
    // stop within read address bits: no read-out
    begin_frame();
    for (int i = 7; i > 3; i--)
      master.put_bit(i == 7, 1'b0);
    master.stop_cond();
    check({7'h00, dut_oe}, 8'h00);
    check({4'h0, last_addr}, 8'h05);
    // a stop in the second don't-care period is ignored and the write goes on
    begin_frame();
    for (int i = 7; i > 1; i--)
      master.put_bit(i == 6 || i == 4 || i == 3 || i == 2, 1'b0);
    master.put_rising_bit();
    master.put_bit(1'b0, 1'b0);
    master.send_byte(8'hC3, 1'b0);
    master.stop_cond();
    check({7'h00, prog_busy}, 8'h01);
    wait_idle();
    read_byte(4'h7, rd);
    check(rd, 8'hC3);
    // read attempt during programming is ignored
    write_byte(4'h9, 8'h3C);
    begin_frame();
    master.send_byte({CMD_READ, 4'h9, 2'b00}, 1'b1);
    master.stop_cond();
    check({6'h00, prog_busy, dut_oe}, 8'h02);
    wait_idle();
    read_byte(4'h9, rd);
    check(rd, 8'h3C);
    // second reset restores the erased array
    do_reset();
    read_byte(rows[0].addr, rd);
    check(rd, 8'hFF);
    end_sim();
  end
endmodule : testbench
